// ---- hw/lccr_pkg.sv ----
// constants, layouts and carrier types of the local config register bank
// assumes one 50 MHz clock shared by the whole bank
package lccr_pkg;
   // internal register addresses
   localparam logic [7:0] ADDR_MEM_CTRL  = 8'h30;
   localparam logic [7:0] ADDR_PWR_CTRL  = 8'h31;
   localparam logic [7:0] ADDR_CHAN_IRQ  = 8'h34;
   localparam logic [7:0] ADDR_CHAN_EN   = 8'h40;
   localparam logic [7:0] ADDR_SHARED_EN = 8'h42;
   localparam logic [7:0] ADDR_CHAN_CFG  = 8'h4C;
   localparam logic [7:0] ADDR_PRESCALE  = 8'h50;
   localparam logic [7:0] ALIAS_MASK     = 8'h20;  // bit 5 ignored 40h-7Fh
   // memory control, shared enable and prescaler field positions
   localparam int MC_FLAG_DLY  = 7;
   localparam int MC_FLAG_TICK = 6;
   localparam int MC_DATA_IN   = 4;
   localparam int MC_SELECT    = 3;
   localparam int MC_CLOCK     = 2;
   localparam int MC_OE        = 1;
   localparam int MC_DOUT      = 0;
   localparam int SH_EN_BIT    = 7;
   localparam int PS_SEL_HI    = 5;
   localparam int PS_SEL_LO    = 2;
   // reset values
   localparam logic [7:0] MEM_CTRL_RST  = 8'h00;
   localparam logic [7:0] PWR_CTRL_RST  = 8'h00;
   localparam logic [7:0] SHARED_EN_RST = 8'h80;
   localparam logic [7:0] PRESCALE_RST  = 8'hF6;
   localparam logic [7:0] CHAN_CFG_RST  = 8'h00;
   localparam logic [7:0] CHAN_EN_RST   = 8'hFF;
   // timing
   localparam int CLK_NS      = 20;
   localparam int PACE_CYCLES = 70;
   localparam int LD_BIT_NS   = 1400;  // loader serial bit time
   localparam int LD_HALF     = (LD_BIT_NS / 2 + CLK_NS - 1) / CLK_NS;
   localparam int LD_BITS     = 64;    // data bits fetched by the loader
   localparam int LD_CMD_BITS = 9;
   localparam logic [8:0] LD_CMD = 9'h180;  // start, read, address 0
   // configuration space dword indices
   localparam logic [5:0] CFG_ID      = 6'h00;
   localparam logic [5:0] CFG_CAP_PTR = 6'h0D;
   localparam logic [5:0] CFG_PM_CAP  = 6'h10;
   localparam logic [5:0] CFG_PM_CSR  = 6'h11;
   localparam logic [7:0] CAP_START   = 8'h40;
   localparam logic [15:0] PM_CAPS    = 16'h0002;  // arbitrary value

   typedef enum logic [1:0] {
      LD_RESET = 2'b00,
      LD_SEND  = 2'b01,
      LD_READ  = 2'b10,
      LD_DONE  = 2'b11
   } lccr_ld_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } lccr_bus_req_t;

   typedef struct packed {
      logic cs;
      logic ck;
      logic oe;
      logic dout;
   } lccr_mem_pins_t;
endpackage

// ---- hw/lccr_regs.sv ----
// local configuration and control register bank with config memory loader
// assumes internal bus strobes and pins synchronous to mclk
`timescale 1ns/1ns
`default_nettype none

module lccr_regs #(
   parameter int PACE_CYCLES = lccr_pkg::PACE_CYCLES,
   parameter int LD_HALF     = lccr_pkg::LD_HALF,
   parameter int LD_BITS     = lccr_pkg::LD_BITS
) (
   input  wire  logic                     mclk,
   input  wire  logic                     rstn,
   input  wire  lccr_pkg::lccr_bus_req_t  busReq,
   output logic [7:0]                     busRdData,
   output logic                           busRdValid,
   input  wire  logic                     cfgRd,
   input  wire  logic [5:0]               cfgAddr,
   output logic [31:0]                    cfgRdData,
   output logic                           cfgRdValid,
   input  wire  logic [15:0]              deviceIdSetup,
   input  wire  logic [15:0]              vendorIdSetup,
   input  wire  logic [1:0]               pwrState,
   input  wire  logic [7:0]               chanIrq,
   input  wire  logic [2:0]               chanSel,
   input  wire  logic                     chanReq,
   output logic                           chanGrant,
   input  wire  logic                     sharedReq,
   output logic                           sharedGrant,
   output lccr_pkg::lccr_mem_pins_t       memPins,
   input  wire  logic                     memDataIn,
   output logic [15:0]                    loadWord,
   output logic                           loadValid,
   output logic                           loadBusy,
   output logic                           lineDriverEn,
   output logic                           localClkEn,
   output logic                           oscEn,
   output logic [7:0]                     chanCfg,
   output logic [3:0]                     prescaleDiv
);
   localparam logic [6:0] PACE_LAST = 7'(PACE_CYCLES - 1);
   localparam logic [6:0] HALF_LAST = 7'(LD_HALF - 1);
   localparam logic [6:0] BITS_LAST = 7'(LD_BITS - 1);
   localparam logic [6:0] CMD_LAST  = 7'(lccr_pkg::LD_CMD_BITS - 1);
   localparam logic [3:0] DIV_RST   = 4'(4'h1 << {
      lccr_pkg::PRESCALE_RST[lccr_pkg::PS_SEL_HI],
      lccr_pkg::PRESCALE_RST[lccr_pkg::PS_SEL_LO]});

   lccr_pkg::lccr_ld_state_t ldState_reg, ldState_next;  // loader phase
   logic [6:0]  halfCnt_reg, halfCnt_next;   // half bit timer
   logic [6:0]  bitCnt_reg, bitCnt_next;     // bits in phase
   logic        ldCk_reg, ldCk_next;         // loader serial clock
   logic [15:0] shift_reg, shift_next;       // incoming data
   logic        ldValid_reg, ldValid_next;   // word strobe
   logic [8:0]  cmdSh;                       // command bit shifter
   logic        loading;

   // loader sequencing: send read command, then clock data in
   always_comb begin
      ldState_next = ldState_reg;
      halfCnt_next = halfCnt_reg;
      bitCnt_next  = bitCnt_reg;
      ldCk_next    = ldCk_reg;
      shift_next   = shift_reg;
      ldValid_next = 1'b0;
      case (ldState_reg)
         lccr_pkg::LD_RESET: begin
            // one idle cycle so select rises after reset release
            ldState_next = lccr_pkg::LD_SEND;
         end
         lccr_pkg::LD_SEND, lccr_pkg::LD_READ: begin
            if (halfCnt_reg == HALF_LAST) begin
               halfCnt_next = 7'h00;
               ldCk_next    = ~ldCk_reg;
               if (ldCk_reg) begin
                  // falling edge closes a bit
                  bitCnt_next = bitCnt_reg + 7'h01;
                  if (ldState_reg == lccr_pkg::LD_SEND &&
                      bitCnt_reg == CMD_LAST) begin
                     ldState_next = lccr_pkg::LD_READ;
                     bitCnt_next  = 7'h00;
                  end else if (ldState_reg == lccr_pkg::LD_READ &&
                               bitCnt_reg == BITS_LAST) begin
                     ldState_next = lccr_pkg::LD_DONE;
                  end
               end else if (ldState_reg == lccr_pkg::LD_READ) begin
                  // rising edge samples the memory data
                  shift_next   = {shift_reg[14:0], memDataIn};
                  ldValid_next = (bitCnt_reg[3:0] == 4'hF);
               end
            end else begin
               halfCnt_next = halfCnt_reg + 7'h01;
            end
         end
         lccr_pkg::LD_DONE: begin
            ldCk_next = 1'b0;  // software owns the pins from here
         end
         default: begin
            ldState_next = lccr_pkg::LD_DONE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ldState_reg <= lccr_pkg::LD_RESET;
         halfCnt_reg <= 7'h00;
         bitCnt_reg  <= 7'h00;
         ldCk_reg    <= 1'b0;
         shift_reg   <= 16'h0000;
         ldValid_reg <= 1'b0;
      end else begin
         ldState_reg <= ldState_next;
         halfCnt_reg <= halfCnt_next;
         bitCnt_reg  <= bitCnt_next;
         ldCk_reg    <= ldCk_next;
         shift_reg   <= shift_next;
         ldValid_reg <= ldValid_next;
      end
   end

   assign loading   = (ldState_reg != lccr_pkg::LD_DONE);
   assign loadBusy  = loading;
   assign loadWord  = shift_reg;
   assign loadValid = ldValid_reg;
   assign cmdSh     = lccr_pkg::LD_CMD << bitCnt_reg[3:0];

   // register state
   logic [3:0] memCtrl_reg, memCtrl_next;     // select, clock, oe, dout
   logic       flagTick_reg, flagTick_next;   // pacing tick flag
   logic       flagDly_reg, flagDly_next;     // pacing delayed flag
   logic [6:0] paceCnt_reg, paceCnt_next;     // 70-cycle pacer
   logic [5:0] pwrCtrl_reg, pwrCtrl_next;     // three power fields
   logic [7:0] chanEn_reg, chanEn_next;       // channel access enables
   logic       sharedEn_reg, sharedEn_next;   // shared status access
   logic [7:0] chanCfg_reg, chanCfg_next;
   logic [7:0] prescale_reg, prescale_next;
   logic [7:0] rdData_reg, rdData_next;
   logic       rdValid_reg;
   logic [7:0] addrDec;   // address with alias bit folded
   logic       tick;
   logic       memWr;

   // 40h-7Fh repeats every 32 bytes
   assign addrDec = (busReq.addr[7:6] == 2'b01) ?
                    (busReq.addr & ~lccr_pkg::ALIAS_MASK) : busReq.addr;
   assign tick  = (paceCnt_reg == PACE_LAST);
   assign memWr = busReq.wr && addrDec == lccr_pkg::ADDR_MEM_CTRL;

   // register write and read-mux logic
   always_comb begin
      memCtrl_next  = memCtrl_reg;
      pwrCtrl_next  = pwrCtrl_reg;
      chanEn_next   = chanEn_reg;
      sharedEn_next = sharedEn_reg;
      chanCfg_next  = chanCfg_reg;
      prescale_next = prescale_reg;
      rdData_next   = rdData_reg;
      paceCnt_next  = tick ? 7'h00 : paceCnt_reg + 7'h01;
      // tick sets the tick flag and loads it into the delayed flag, write clears both; tick wins a collision
      flagTick_next = tick ? 1'b1 : (memWr ? 1'b0 : flagTick_reg);
      flagDly_next  = tick ? flagTick_reg : (memWr ? 1'b0 : flagDly_reg);
      if (busReq.wr) begin
         case (addrDec)
            lccr_pkg::ADDR_MEM_CTRL:  memCtrl_next  = busReq.wdata[3:0];
            lccr_pkg::ADDR_PWR_CTRL:  pwrCtrl_next  = busReq.wdata[5:0];
            lccr_pkg::ADDR_CHAN_EN:   chanEn_next   = busReq.wdata;
            lccr_pkg::ADDR_SHARED_EN:
               sharedEn_next = busReq.wdata[lccr_pkg::SH_EN_BIT];
            lccr_pkg::ADDR_CHAN_CFG:  chanCfg_next  = busReq.wdata;
            lccr_pkg::ADDR_PRESCALE:  prescale_next = busReq.wdata;
            default: begin
            end
         endcase
      end
      if (busReq.rd) begin
         case (addrDec)
            lccr_pkg::ADDR_MEM_CTRL:
               rdData_next = {flagDly_reg, flagTick_reg, 1'b0,
                              memDataIn, memCtrl_reg};
            lccr_pkg::ADDR_PWR_CTRL:  rdData_next = {2'b00, pwrCtrl_reg};
            lccr_pkg::ADDR_CHAN_IRQ:  rdData_next = chanIrq;
            lccr_pkg::ADDR_CHAN_EN:   rdData_next = chanEn_reg;
            lccr_pkg::ADDR_SHARED_EN: rdData_next = {sharedEn_reg, 7'h00};
            lccr_pkg::ADDR_CHAN_CFG:  rdData_next = chanCfg_reg;
            lccr_pkg::ADDR_PRESCALE:  rdData_next = prescale_reg;
            default:                  rdData_next = 8'h00;
         endcase
      end
   end

   // memory and power control clear on reset
   // shared enable resets set; prescaler F6h
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         memCtrl_reg  <= lccr_pkg::MEM_CTRL_RST[3:0];
         flagTick_reg <= lccr_pkg::MEM_CTRL_RST[lccr_pkg::MC_FLAG_TICK];
         flagDly_reg  <= lccr_pkg::MEM_CTRL_RST[lccr_pkg::MC_FLAG_DLY];
         paceCnt_reg  <= 7'h00;
         pwrCtrl_reg  <= lccr_pkg::PWR_CTRL_RST[5:0];
         chanEn_reg   <= lccr_pkg::CHAN_EN_RST;
         sharedEn_reg <= lccr_pkg::SHARED_EN_RST[lccr_pkg::SH_EN_BIT];
         chanCfg_reg  <= lccr_pkg::CHAN_CFG_RST;
         prescale_reg <= lccr_pkg::PRESCALE_RST;
         rdData_reg   <= 8'h00;
         rdValid_reg  <= 1'b0;
      end else begin
         memCtrl_reg  <= memCtrl_next;
         flagTick_reg <= flagTick_next;
         flagDly_reg  <= flagDly_next;
         paceCnt_reg  <= paceCnt_next;
         pwrCtrl_reg  <= pwrCtrl_next;
         chanEn_reg   <= chanEn_next;
         sharedEn_reg <= sharedEn_next;
         chanCfg_reg  <= chanCfg_next;
         prescale_reg <= prescale_next;
         rdData_reg   <= rdData_next;
         rdValid_reg  <= busReq.rd;
      end
   end

   assign busRdData  = rdData_reg;
   assign busRdValid = rdValid_reg;
   assign chanCfg    = chanCfg_reg;  // bit 5 set by software

   // then select and clock follow bits 3 and 2
   // data pin driven by the loader while sending, then only while bit 1 is set
   always_comb begin
      if (loading) begin
         memPins.cs   = (ldState_reg != lccr_pkg::LD_RESET);
         memPins.ck   = ldCk_reg;
         memPins.oe   = (ldState_reg == lccr_pkg::LD_SEND);
         memPins.dout = cmdSh[8];
      end else begin
         memPins.cs   = memCtrl_reg[lccr_pkg::MC_SELECT];
         memPins.ck   = memCtrl_reg[lccr_pkg::MC_CLOCK];
         memPins.oe   = memCtrl_reg[lccr_pkg::MC_OE];
         memPins.dout = memCtrl_reg[lccr_pkg::MC_DOUT];
      end
   end

   // channel gate, grant only for a selected channel whose enable bit is set
   assign chanGrant   = chanReq && chanEn_reg[chanSel];
   // shared status reachable only when enabled
   assign sharedGrant = sharedReq && sharedEn_reg;

   // code n disables from state Dn upward, code 0 never disables
   function automatic logic isOff(input logic [1:0] fld,
                                  input logic [1:0] st);
      isOff = (fld != 2'b00) && (st >= fld);
   endfunction

   logic       drvEn_reg, lclkEn_reg, oscEn_reg;
   logic [3:0] div_reg;
   logic [3:0] div_next;

   // only bits 5 and 2 choose the factor
   assign div_next = 4'(4'h1 << {prescale_reg[lccr_pkg::PS_SEL_HI],
                                  prescale_reg[lccr_pkg::PS_SEL_LO]});

   // registered enables keep outputs glitch free
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         drvEn_reg  <= 1'b1;
         lclkEn_reg <= 1'b1;
         oscEn_reg  <= 1'b1;
         div_reg    <= DIV_RST;
      end else begin
         drvEn_reg  <= !isOff(pwrCtrl_reg[5:4], pwrState);
         lclkEn_reg <= !isOff(pwrCtrl_reg[3:2], pwrState);
         oscEn_reg  <= !isOff(pwrCtrl_reg[1:0], pwrState);
         div_reg    <= div_next;
      end
   end

   assign lineDriverEn = drvEn_reg;
   assign localClkEn   = lclkEn_reg;
   assign oscEn        = oscEn_reg;
   assign prescaleDiv  = div_reg;

   logic [31:0] cfgData_reg, cfgData_next;
   logic        cfgValid_reg;

   // configuration header read port
   always_comb begin
      case (cfgAddr)
         lccr_pkg::CFG_ID:      cfgData_next = {deviceIdSetup, vendorIdSetup};
         // capability list points at power block
         lccr_pkg::CFG_CAP_PTR: cfgData_next = {24'h000000,
                                               lccr_pkg::CAP_START};
         lccr_pkg::CFG_PM_CAP:  cfgData_next = {lccr_pkg::PM_CAPS, 16'h0000};
         lccr_pkg::CFG_PM_CSR:  cfgData_next = {30'h00000000, pwrState};
         default:               cfgData_next = 32'h00000000;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfgData_reg  <= 32'h00000000;
         cfgValid_reg <= 1'b0;
      end else begin
         cfgData_reg  <= cfgRd ? cfgData_next : cfgData_reg;
         cfgValid_reg <= cfgRd;
      end
   end

   assign cfgRdData  = cfgData_reg;
   assign cfgRdValid = cfgValid_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_load_owns_pins: assert property (
      ldState_reg == lccr_pkg::LD_SEND |-> memPins.cs)
      else $error("select low during load");
   a_select_follows: assert property (
      !loading && memWr |=> memPins.cs == $past(busReq.wdata[3]) &&
      memPins.ck == $past(busReq.wdata[2]))
      else $error("pins do not follow control");
   a_tick_period: assert property (
      tick |=> flagTick_reg ##69 tick)
      else $error("pacing tick not every 70");
   a_delayed_copy: assert property (
      tick |=> flagDly_reg == $past(flagTick_reg))
      else $error("delayed flag not loaded");
   a_write_clears: assert property (
      memWr && !tick |=> !flagTick_reg && !flagDly_reg)
      else $error("write did not clear flags");
   a_data_in_live: assert property (
      busReq.rd && addrDec == lccr_pkg::ADDR_MEM_CTRL |=>
      busRdData[4] == $past(memDataIn) && busRdData[5] == 1'b0)
      else $error("data in bit wrong");
   a_data_tristate: assert property (
      !loading && !memCtrl_reg[1] |-> !memPins.oe)
      else $error("data pin driven while off");
   a_reset_clears: assert property (
      $rose(rstn) |-> memCtrl_reg == 4'h0 && pwrCtrl_reg == 6'h00)
      else $error("control not cleared");
   a_d3_driver_off: assert property (
      pwrCtrl_reg[5:4] == 2'b11 && pwrState == 2'b11 |=> !lineDriverEn)
      else $error("driver not disabled in D3");
   a_field_never: assert property (
      pwrCtrl_reg[3:2] == 2'b00 |=> localClkEn)
      else $error("local clock gated wrongly");
   a_irq_view: assert property (
      busReq.rd && addrDec == lccr_pkg::ADDR_CHAN_IRQ |=>
      busRdData == $past(chanIrq))
      else $error("irq view wrong");
   a_chan_gate: assert property (
      chanGrant |-> chanReq && chanEn_reg[chanSel])
      else $error("channel granted while disabled");
   a_shared_gate: assert property (
      sharedGrant |-> sharedEn_reg)
      else $error("shared access while disabled");
   a_prescale_rst: assert property (
      $rose(rstn) |-> prescale_reg == 8'hF6 && prescaleDiv == 4'h8)
      else $error("prescaler reset wrong");
   a_prescale_div: assert property (
      busReq.wr && addrDec == lccr_pkg::ADDR_PRESCALE |=> ##1
      prescaleDiv == 4'(4'h1 << {$past(busReq.wdata[5], 2),
                                  $past(busReq.wdata[2], 2)}))
      else $error("prescale factor wrong");
   a_cfg_ids: assert property (
      cfgRd && cfgAddr == lccr_pkg::CFG_ID |=>
      cfgRdData == $past({deviceIdSetup, vendorIdSetup}))
      else $error("id readback wrong");
   a_cap_header: assert property (
      cfgRd && cfgAddr == lccr_pkg::CFG_PM_CAP |=> cfgRdData[15:0] == 16'h0)
      else $error("capability header nonzero");
   a_unmapped_zero: assert property (
      busReq.rd && addrDec == 8'h38 |=> busRdData == 8'h00)
      else $error("unmapped read nonzero");

   c_load_done:  cover property (loading ##1 !loading);
   c_word_load:  cover property (loadValid);
   c_flag_pair:  cover property (flagDly_reg && flagTick_reg);
   c_d3_off:     cover property (!oscEn);
endmodule

`default_nettype wire

// ---- verification/lccr_mem_model.sv ----
// behavioural serial configuration memory on the far side of the pins
// assumes the bank drives cs, ck and the data enable from mclk logic
`timescale 1ns/1ns
`default_nettype none
module lccr_mem_model (
   input  wire logic                     mclk,
   input  wire lccr_pkg::lccr_mem_pins_t memPins,
   output logic                         memDataIn
);
   logic [7:0] bitCnt;  // clock rises since select went high
   logic       tog;     // filler for a released line
   initial bitCnt = 8'h00;
   initial tog = 1'h0;
   // restart the count at each new select
   always @(posedge memPins.cs) bitCnt <= 8'h00;
   // count clock rises inside a frame only
   always @(posedge memPins.ck) if (memPins.cs) bitCnt <= bitCnt + 8'h01;
   // released line must not look stable, or it hides missing drivers
   always @(posedge mclk) tog <= ~tog;
   // wire level: bank drive wins, memory answers ones after the command
   assign memDataIn = memPins.oe ? memPins.dout :
                      (memPins.cs && bitCnt >= 8'h09) ? 1'h1 : tog;
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the local config register bank
// assumes the memory model on the pins and a 50 MHz mclk
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic                    mclk, rstn, cfgRd, chanReq, sharedReq, memDataIn;
   lccr_pkg::lccr_bus_req_t busReq;
   lccr_pkg::lccr_mem_pins_t memPins;
   logic [5:0]              cfgAddr;
   logic [15:0]             devId, venId, loadWord;
   logic [1:0]              pwrState;
   logic [7:0]              chanIrq, busRdData, chanCfg, rd;
   logic [2:0]              chanSel;
   logic [31:0]             cfgRdData;
   logic [3:0]              prescaleDiv;
   logic                    busRdValid, cfgRdValid, chanGrant, sharedGrant;
   logic                    loadValid, loadBusy, lineDriverEn, localClkEn;
   logic                    oscEn;
   int                      errorCnt, checks, n, words;
   logic [7:0]              pv [6] = '{8'hF6, 8'hF2, 8'hD6, 8'hD2,
                                       8'h24, 8'h00};
   logic [3:0]              dv [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h1};
   // short loader so the run stays small
   lccr_regs #(.PACE_CYCLES(70), .LD_HALF(2), .LD_BITS(16)) dut (
      .mclk(mclk), .rstn(rstn), .busReq(busReq), .busRdData(busRdData),
      .busRdValid(busRdValid), .cfgRd(cfgRd), .cfgAddr(cfgAddr),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .deviceIdSetup(devId),
      .vendorIdSetup(venId), .pwrState(pwrState), .chanIrq(chanIrq),
      .chanSel(chanSel), .chanReq(chanReq), .chanGrant(chanGrant),
      .sharedReq(sharedReq), .sharedGrant(sharedGrant), .memPins(memPins),
      .memDataIn(memDataIn), .loadWord(loadWord), .loadValid(loadValid),
      .loadBusy(loadBusy), .lineDriverEn(lineDriverEn),
      .localClkEn(localClkEn), .oscEn(oscEn), .chanCfg(chanCfg),
      .prescaleDiv(prescaleDiv));
   lccr_mem_model mem (.mclk(mclk), .memPins(memPins), .memDataIn(memDataIn));
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   // every loaded word carries the ones the memory answered
   always @(negedge mclk) if (loadValid === 1'h1) begin
      words++;
      chk(loadWord, 16'hFFFF);
   end
   // hang guard, far beyond the few hundred cycles needed
   initial begin
      #200000;
      errorCnt++;
      end_sim;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk) busReq <= {1'h1, 1'h0, a, d};
      @(negedge mclk) busReq <= '0;
   endtask
   // read data is taken in the single cycle the valid pulse stands
   task automatic rdb(input logic [7:0] a);
      @(negedge mclk) busReq <= {1'h0, 1'h1, a, 8'h00};
      @(negedge mclk) busReq <= '0;
      chk(busRdValid, 1'h1);
      rd = busRdData;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      rdb(a);
      chk(rd, e);
   endtask
   task automatic cfg(input logic [5:0] i, input logic [31:0] e);
      @(negedge mclk) cfgRd <= 1'h1;
      cfgAddr <= i;
      @(negedge mclk) cfgRd <= 1'h0;
      chk(cfgRdValid, 1'h1);
      chk(cfgRdData, e);
   endtask
   // enabled unless field set and state at or past it
   function automatic logic en(input int f, input int s);
      return !((f % 4) != 0 && s >= (f % 4));
   endfunction
   task automatic end_sim;
      $display("errors %0d checks %0d", errorCnt, checks);
      if (errorCnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      rstn = 1'h0; busReq = '0; cfgRd = 1'h0; cfgAddr = 6'h00;
      devId = 16'h1234; venId = 16'h5678; pwrState = 2'h0; chanIrq = 8'h00;
      chanSel = 3'h0; chanReq = 1'h0; sharedReq = 1'h0;
      errorCnt = 0; checks = 0; words = 0;
      repeat (8) @(negedge mclk);
      rstn = 1'h1;
      rdc(lccr_pkg::ADDR_PWR_CTRL, 8'h00);
      rdc(lccr_pkg::ADDR_SHARED_EN, 8'h80);
      rdc(lccr_pkg::ADDR_PRESCALE, 8'hF6);
      chk(prescaleDiv, 4'h8);
      rdb(lccr_pkg::ADDR_MEM_CTRL);
      chk(rd & 8'h2F, 8'h00);
      chk({loadBusy, memPins.cs}, 2'h3);
      n = 0;
      while (loadBusy === 1'h1 && n < 1000) begin
         @(negedge mclk);
         n++;
      end
      chk(words, 1);
      // driven one, then driven zero, seen back on the live pin bit
      wr(lccr_pkg::ADDR_MEM_CTRL, 8'hFF);
      rdb(lccr_pkg::ADDR_MEM_CTRL);
      chk(rd & 8'h3F, 8'h1F);
      chk(memPins, 4'hF);
      wr(lccr_pkg::ADDR_MEM_CTRL, 8'h06);
      rdb(lccr_pkg::ADDR_MEM_CTRL);
      chk(rd & 8'h3F, 8'h06);
      chk(memPins, 4'h6);
      // pacing flags after a write: tick first, delayed one period later
      wr(lccr_pkg::ADDR_MEM_CTRL, 8'h00);
      chk(memPins, 4'h0);
      rdb(lccr_pkg::ADDR_MEM_CTRL);
      for (n = 0; rd[6] !== 1'h1 && n < 40; n++) begin
         chk(rd[7], 1'h0);
         rdb(lccr_pkg::ADDR_MEM_CTRL);
      end
      chk({rd[7:6], n < 36}, 3'h3);
      for (n = 0; rd[7] !== 1'h1 && n < 40; n++) rdb(lccr_pkg::ADDR_MEM_CTRL);
      chk(n < 36, 1'h1);
      // every code against every state, fields kept distinct
      for (int f = 0; f < 4; f++) for (int s = 0; s < 4; s++) begin
         wr(lccr_pkg::ADDR_PWR_CTRL, {2'h0, 2'(f), 2'(f + 1), 2'(f + 2)});
         pwrState = 2'(s);
         repeat (2) @(negedge mclk);
         chk({lineDriverEn, localClkEn, oscEn},
             {en(f, s), en(f + 1, s), en(f + 2, s)});
      end
      chanIrq = 8'hA5;
      rdc(lccr_pkg::ADDR_CHAN_IRQ, 8'hA5);
      chanIrq = 8'h5A;
      rdc(lccr_pkg::ADDR_CHAN_IRQ, 8'h5A);
      wr(lccr_pkg::ADDR_CHAN_EN, 8'h3C);
      rdc(8'h60, 8'h3C);
      chanReq = 1'h1;
      for (int c = 0; c < 8; c++) begin
         @(negedge mclk) chanSel = 3'(c);
         #1 chk(chanGrant, (8'h3C >> c) & 8'h01);
      end
      sharedReq = 1'h1;
      wr(lccr_pkg::ADDR_SHARED_EN, 8'h00);
      chk(sharedGrant, 1'h0);
      wr(lccr_pkg::ADDR_SHARED_EN, 8'h80);
      chk(sharedGrant, 1'h1);
      for (int i = 0; i < 6; i++) begin
         wr(lccr_pkg::ADDR_PRESCALE, pv[i]);
         // divisor is registered once more behind the stored byte
         @(negedge mclk);
         chk(prescaleDiv, dv[i]);
      end
      wr(lccr_pkg::ADDR_CHAN_CFG, 8'h20);
      chk(chanCfg, 8'h20);
      wr(8'h38, 8'hFF);
      rdc(8'h38, 8'h00);
      cfg(lccr_pkg::CFG_ID, {devId, venId});
      devId = 16'hBEEF;
      venId = 16'hCAFE;
      cfg(lccr_pkg::CFG_ID, 32'hBEEFCAFE);
      cfg(lccr_pkg::CFG_CAP_PTR, 32'h00000040);
      cfg(lccr_pkg::CFG_PM_CAP, {lccr_pkg::PM_CAPS, 16'h0000});
      cfg(lccr_pkg::CFG_PM_CSR, {30'h0, pwrState});
      end_sim;
   end
endmodule
`default_nettype wire
